/* dv/buck_mode_voltage_control_test.sv */
/*
 self-checking bench of bc_top: mode table, fused code load, read-only voltage codes,
 current-limit blanking, debounce, status, mask and interrupt over wishbone classic.
 assumes the bench alone drives every input; the debounce count is shortened to DEB.
*/
`include "bc_params.svh"
module buck_mode_voltage_control_test import bc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DEB = 40;
  typedef struct {string nm; logic [31:0] v;} bc_note_t;
  bc_note_t notes[$];
  int error_cnt = 0;
  int num_checks = 0;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, look = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o, irq_o, discharge_o, ccm_o, hs_off_o, ls_off_o;
  logic hs_limit_i = 0, ls_limit_i = 0, light_load_i = 0, cycle_start_i = 0;
  bc_pstate_t pstate_i = BC_PS_OFF;
  logic [5:0] fused_code_i = 6'h00, f;
  logic [4:0] c;
  bc_mode_t mode_o, m;
  logic [3:0] vcode_o;
  logic [11:0] vout_mv_o;

  bc_top #(.DEB_CYCLES(DEB), .DEB_CNT_W(18)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq_o(irq_o), .pstate_i(pstate_i), .fused_code_i(fused_code_i),
    .hs_limit_i(hs_limit_i), .ls_limit_i(ls_limit_i), .light_load_i(light_load_i),
    .cycle_start_i(cycle_start_i), .mode_o(mode_o), .discharge_o(discharge_o),
    .ccm_o(ccm_o), .hs_off_o(hs_off_o), .ls_off_o(ls_off_o), .vcode_o(vcode_o),
    .vout_mv_o(vout_mv_o));

  initial begin
    forever #20 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    if (error_cnt == 0 && num_checks > 0 && notes.size() == 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ==========================================================================
  // result monitor
  task automatic chk(input logic [31:0] seen);
    bc_note_t n;
    if (notes.size() > 0) n = notes.pop_front();
    else n = '{"none", 32'hx};
    num_checks++;
    if (seen !== n.v) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n.nm, n.v, seen);
    end
  endtask

  task automatic cmp_rd();
    chk(wb_dat_o);
  endtask

  task automatic cmp_port();
    logic [31:0] s;
    case (notes[0].nm)
      "mode": s = 32'(mode_o);
      "dis": s = 32'(discharge_o);
      "ccm": s = 32'(ccm_o);
      "hs": s = 32'(hs_off_o);
      "ls": s = 32'(ls_off_o);
      "vcode": s = 32'(vcode_o);
      "vmv": s = 32'(vout_mv_o);
      default: s = 32'(irq_o);
    endcase
    chk(s);
  endtask

  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) cmp_rd();
    if (look) begin
      while (notes.size() > 0) cmp_port();
    end
  end

  // ==========================================================================
  // drivers
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      give_verdict();
    end
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    notes.push_back('{nm, e});
    wb(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic expect_port(input string nm, input logic [31:0] v);
    notes.push_back('{nm, v});
  endtask

  task automatic look_now();
    look <= 1;
    @(posedge clk_i);
    look <= 0;
    @(posedge clk_i);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(23270));
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    rd(`BC_ADR_CTRL, 32'h01, "ctrl");
    expect_port("vmv", 32'd1800);
    expect_port("dis", 32'h1);
    look_now();
    f = 6'($urandom) | 6'h20;
    fused_code_i <= f;
    pstate_i <= BC_PS_RUN;
    settle(5);
    expect_port("mode", 32'(BC_MODE_ADAPT));
    expect_port("vcode", 32'(f[3:0]));
    expect_port("vmv", 32'(1800 + 100 * f[3:0]));
    look_now();
    for (int k = 0; k < 3; k++) begin
      rd(8'(`BC_ADR_VRUN + 4 * k), 32'(f), "vcode_reg");
      wr(8'(`BC_ADR_VRUN + 4 * k), 32'(~f));
      rd(8'(`BC_ADR_VRUN + 4 * k), 32'(f), "vcode_ro");
    end
    for (int i = 0; i < 16; i++) begin
      c = (i == 0) ? 5'h00 : (i == 1) ? 5'h0f : {4'($urandom), 1'b1};
      wr(`BC_ADR_CTRL, 32'(c));
      for (int p = 1; p < 4; p++) begin
        pstate_i <= bc_pstate_t'(p);
        light_load_i <= 1'($urandom);
        settle(5);
        if (!(c[0] && (p == 1 || (p == 2 && c[1]) || (p == 3 && c[2])))) m = BC_MODE_OFF;
        else if (c[4]) m = BC_MODE_FPWM;
        else if (p != 1 && c[3]) m = BC_MODE_LOWB;
        else m = BC_MODE_ADAPT;
        expect_port("mode", 32'(m));
        expect_port("dis", 32'(m == BC_MODE_OFF));
        expect_port("ccm", 32'(m == BC_MODE_FPWM || (m == BC_MODE_ADAPT && !light_load_i)));
        expect_port("vcode", 32'(f[3:0]));
        look_now();
      end
    end
    wb(1'b1, `BC_ADR_CTRL, 32'h00, 4'h0);
    rd(`BC_ADR_CTRL, 32'(c), "ctrl_sel");
    wr(`BC_ADR_CTRL, 32'h01);
    pstate_i <= BC_PS_RUN;
    wr(`BC_ADR_MASK, 32'h1);
    hs_limit_i <= 1;
    settle(4);
    expect_port("hs", 32'h1);
    look_now();
    rd(`BC_ADR_SENSE, 32'h1, "sense");
    rd(`BC_ADR_STATUS, 32'h0, "status_early");
    settle(DEB + 10);
    rd(`BC_ADR_STATUS, 32'h1, "status_hs");
    expect_port("irq", 32'h1);
    look_now();
    hs_limit_i <= 0;
    settle(4);
    cycle_start_i <= 1;
    @(posedge clk_i);
    cycle_start_i <= 0;
    settle(3);
    expect_port("hs", 32'h0);
    look_now();
    wr(`BC_ADR_STATUS, 32'h1);
    rd(`BC_ADR_STATUS, 32'h0, "status_clr");
    ls_limit_i <= 1;
    settle(DEB / 2);
    ls_limit_i <= 0;
    settle(4);
    ls_limit_i <= 1;
    settle(DEB / 2);
    rd(`BC_ADR_STATUS, 32'h0, "status_gap");
    expect_port("ls", 32'h1);
    look_now();
    settle(DEB);
    rd(`BC_ADR_STATUS, 32'h2, "status_ls");
    expect_port("irq", 32'h0);
    look_now();
    wr(`BC_ADR_MASK, 32'h3);
    settle(3);
    expect_port("irq", 32'h1);
    look_now();
    ls_limit_i <= 0;
    settle(4);
    wr(`BC_ADR_STATUS, 32'h2);
    settle(3);
    expect_port("irq", 32'h0);
    look_now();
    rd(8'h20, 32'h0, "unmapped");
    give_verdict();
  end
endmodule // buck_mode_voltage_control_test

/* src/bc_debounce.sv */
/*
 persistence filter: held_o rises once lvl_i has been high for more than n cycles in a row.
 assumes lvl_i is already synchronous.
*/
module bc_debounce #(
  parameter int N = 200000,
  parameter int CNT_W = 18
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic lvl_i, // fault level
  output logic held_o // fault persisted past the limit
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic held;
  } bc_deb_state_t;

  bc_deb_state_t q;
  bc_deb_state_t d;

  always_comb begin
    d = q;
    if (!lvl_i) begin
      d.cnt = '0;
      d.held = 1'b0;
    end else if (q.cnt == CNT_W'(N)) begin
      d.held = 1'b1;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign held_o = q.held;

  property p_deb_persist;
    @(posedge clk_i) disable iff (rst_i)
    $rose(held_o) |-> $past(lvl_i) && $past(q.cnt) == CNT_W'(N);
  endproperty
  a_deb_persist: assert property (p_deb_persist) else $error("held rose too early");

  property p_deb_drop;
    @(posedge clk_i) disable iff (rst_i)
    !lvl_i |=> !held_o && q.cnt == '0;
  endproperty
  a_deb_drop: assert property (p_deb_drop) else $error("held survived a gap");
endmodule // bc_debounce

/* src/bc_params.svh */
/*
 constants of the buck mode and voltage control block: offsets, field positions, reset values,
 timing counts. assumes a 25 MHz system clock.
*/
`ifndef BC_PARAMS_SVH
`define BC_PARAMS_SVH

// ==========================================================================
// register byte addresses
`define BC_ADR_CTRL 8'h00
`define BC_ADR_VRUN 8'h04
`define BC_ADR_VSTBY 8'h08
`define BC_ADR_VSLP 8'h0c
`define BC_ADR_STATUS 8'h10
`define BC_ADR_MASK 8'h14
`define BC_ADR_SENSE 8'h18
`define BC_ADR_STATE 8'h1c

// ==========================================================================
// control field positions and reset values
`define BC_CTRL_EN 0
`define BC_CTRL_STBY_EN 1
`define BC_CTRL_SLEEP_EN 2
`define BC_CTRL_LOW_BIAS 3
`define BC_CTRL_FPWM 4
`define BC_CTRL_RST 5'h01

// ==========================================================================
// timing and voltage decode
`define BC_CLK_KHZ 25000
`define BC_DEB_TIME_US 8000
`define BC_DEB_CYCLES (`BC_DEB_TIME_US * `BC_CLK_KHZ / 1000)
`define BC_VOUT_BASE_MV 1800
`define BC_VOUT_STEP_MV 100

`endif

/* src/bc_pkg.sv */
/*
 types of the buck mode and voltage control block.
 assumes nothing beyond the parameter header.
*/
package bc_pkg;

  typedef enum logic [1:0] {
    BC_PS_OFF = 2'b00,
    BC_PS_RUN = 2'b01,
    BC_PS_STBY = 2'b10,
    BC_PS_SLEEP = 2'b11
  } bc_pstate_t;

  typedef enum logic [1:0] {
    BC_MODE_OFF = 2'b00,
    BC_MODE_ADAPT = 2'b01,
    BC_MODE_FPWM = 2'b10,
    BC_MODE_LOWB = 2'b11
  } bc_mode_t;

  typedef struct packed {
    logic [4:0] ctrl;
    logic [5:0] vrun;
    logic [5:0] vstby;
    logic [5:0] vslp;
    logic [1:0] status;
    logic [1:0] mask;
    bc_pstate_t pprev;
    logic ack;
    logic [31:0] rdata;
    logic irq;
    bc_mode_t mode;
    logic discharge;
    logic ccm;
    logic hs_off;
    logic ls_off;
    logic [3:0] vcode;
    logic [11:0] vout_mv;
  } bc_state_t;

endpackage

/* src/bc_sync.sv */
/*
 two flip-flop synchroniser for a vector of unrelated levels.
 assumes each bit is a slow level from outside the clock domain.
*/
module bc_sync #(
  parameter int W = 3
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic [W-1:0] d_i, // asynchronous levels
  output logic [W-1:0] q_o // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bc_sync_state_t;

  bc_sync_state_t q;
  bc_sync_state_t d;

  always_comb begin
    d = q;
    d.s1 = d_i;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign q_o = q.s2;
endmodule // bc_sync

/* src/bc_top.sv */
/*
 buck converter c mode and voltage control: mode select per power state, cycle-by-cycle
 current limit, debounced limit interrupt, fused voltage code load, wishbone classic slave.
 assumes pstate_i, cycle_start_i and fused_code_i come from logic on clk_i; the limit and
 load comparators arrive asynchronously.
*/
// Added by the designer: the register offsets and register access over Wishbone.
// Behaviour
// - adaptive mode picks dcm or ccm from load
// - mode also forced by bus or state changes
// - enable low keeps regulator off and discharging
// - adaptive mode is the default operation
// - forced pwm bit wins whenever enabled
// - run ignores low bias bit
// - standby: off unless standby enable; low bias allowed
// - sleep: off unless sleep enable; low bias allowed
// - mode chosen from state and control bits
// - over-limit switch stays off for cycle rest
// - limit hit sets sense bit
// - status set after limit persists past 8 ms
// - startup to run copies fused voltage code
// - active voltage code follows power state
// - voltage registers ignore bus writes
// - linear decode: 1.80 V base, 0.10 V steps
`include "bc_params.svh"
module bc_top
  import bc_pkg::*;
#(
  parameter int DEB_CYCLES = `BC_DEB_CYCLES,
  parameter int DEB_CNT_W = 18
) (
  input wire logic clk_i, // system clock, 25 MHz
  input wire logic rst_i, // synchronous reset, high
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte selects
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  output logic irq_o, // level interrupt, high
  input wire bc_pstate_t pstate_i, // power state from sequencer
  input wire logic [5:0] fused_code_i, // fused voltage code
  input wire logic hs_limit_i, // high-side over-limit comparator, async
  input wire logic ls_limit_i, // low-side over-limit comparator, async
  input wire logic light_load_i, // light load detector, async
  input wire logic cycle_start_i, // switching cycle start pulse
  output bc_mode_t mode_o, // operating mode
  output logic discharge_o, // output discharge path on
  output logic ccm_o, // continuous conduction forced
  output logic hs_off_o, // high-side switch blanked
  output logic ls_off_o, // low-side switch blanked
  output logic [3:0] vcode_o, // active voltage code
  output logic [11:0] vout_mv_o // active target in millivolts
);

  bc_state_t q;
  bc_state_t d;
  logic [2:0] sync_q;
  logic [1:0] lim_s;
  logic light_s;
  logic [1:0] held;
  logic req;
  logic wr;
  logic startup;
  logic en;
  logic fpwm;
  logic lowb;

  // ==========================================================================
  // input synchronisers and fault filters
  bc_sync #(
    .W(3)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({light_load_i, ls_limit_i, hs_limit_i}),
    .q_o(sync_q)
  );

  assign lim_s = sync_q[1:0];
  assign light_s = sync_q[2];

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_deb
      bc_debounce #(
        .N(DEB_CYCLES),
        .CNT_W(DEB_CNT_W)
      ) u_deb (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lvl_i(lim_s[gi]),
        .held_o(held[gi])
      );
    end
  endgenerate

  // ==========================================================================
  // decode helpers
  assign req = wb_cyc_i & wb_stb_i;
  assign wr = req & q.ack & wb_we_i & wb_sel_i[0];
  assign startup = (q.pprev == BC_PS_OFF) && (pstate_i == BC_PS_RUN);
  assign en = q.ctrl[`BC_CTRL_EN];
  assign fpwm = q.ctrl[`BC_CTRL_FPWM];
  assign lowb = q.ctrl[`BC_CTRL_LOW_BIAS];

  // ==========================================================================
  // next state
  always_comb begin
    d = q;
    d.pprev = pstate_i;
    // ack one cycle after the request, dropped the cycle after
    d.ack = req & ~q.ack;
    if (req & ~q.ack) begin
      case ({wb_adr_i[7:2], 2'b00})
        `BC_ADR_CTRL: d.rdata = {27'h0, q.ctrl};
        `BC_ADR_VRUN: d.rdata = {26'h0, q.vrun};
        `BC_ADR_VSTBY: d.rdata = {26'h0, q.vstby};
        `BC_ADR_VSLP: d.rdata = {26'h0, q.vslp};
        `BC_ADR_STATUS: d.rdata = {30'h0, q.status};
        `BC_ADR_MASK: d.rdata = {30'h0, q.mask};
        `BC_ADR_SENSE: d.rdata = {30'h0, lim_s};
        `BC_ADR_STATE: d.rdata = {26'h0, q.ccm, q.discharge, q.mode, pstate_i};
        default: d.rdata = 32'h0;
      endcase
    end
    // writes land on the edge where the master sees ack; voltage codes have no write path
    if (wr && {wb_adr_i[7:2], 2'b00} == `BC_ADR_CTRL) begin
      d.ctrl = wb_dat_i[4:0];
    end
    if (wr && {wb_adr_i[7:2], 2'b00} == `BC_ADR_MASK) begin
      d.mask = wb_dat_i[1:0];
    end
    if (wr && {wb_adr_i[7:2], 2'b00} == `BC_ADR_STATUS) begin
      d.status = q.status & ~wb_dat_i[1:0];
    end
    d.status = d.status | held;
    d.irq = |(d.status & d.mask);
    // fused code load on the step from the all-off state into run
    if (startup) begin
      d.vrun = fused_code_i;
      d.vstby = fused_code_i;
      d.vslp = fused_code_i;
    end
    // mode selection
    case (pstate_i)
      BC_PS_RUN: begin
        if (!en) begin
          d.mode = BC_MODE_OFF;
        end else if (fpwm) begin
          d.mode = BC_MODE_FPWM;
        end else begin
          d.mode = BC_MODE_ADAPT;
        end
      end
      BC_PS_STBY: begin
        if (!en || !q.ctrl[`BC_CTRL_STBY_EN]) begin
          d.mode = BC_MODE_OFF;
        end else if (fpwm) begin
          d.mode = BC_MODE_FPWM;
        end else if (lowb) begin
          d.mode = BC_MODE_LOWB;
        end else begin
          d.mode = BC_MODE_ADAPT;
        end
      end
      BC_PS_SLEEP: begin
        if (!en || !q.ctrl[`BC_CTRL_SLEEP_EN]) begin
          d.mode = BC_MODE_OFF;
        end else if (fpwm) begin
          d.mode = BC_MODE_FPWM;
        end else if (lowb) begin
          d.mode = BC_MODE_LOWB;
        end else begin
          d.mode = BC_MODE_ADAPT;
        end
      end
      default: d.mode = BC_MODE_OFF;
    endcase
    d.discharge = (d.mode == BC_MODE_OFF);
    case (d.mode)
      BC_MODE_FPWM: d.ccm = 1'b1;
      BC_MODE_ADAPT: d.ccm = ~light_s;
      default: d.ccm = 1'b0;
    endcase
    // blanking holds to the next cycle start, a new hit wins over the release
    d.hs_off = (q.hs_off & ~cycle_start_i) | lim_s[0];
    d.ls_off = (q.ls_off & ~cycle_start_i) | lim_s[1];
    case (pstate_i)
      BC_PS_STBY: d.vcode = q.vstby[3:0];
      BC_PS_SLEEP: d.vcode = q.vslp[3:0];
      default: d.vcode = q.vrun[3:0];
    endcase
    d.vout_mv = 12'(`BC_VOUT_BASE_MV + `BC_VOUT_STEP_MV * int'(d.vcode));
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.ctrl <= `BC_CTRL_RST;
      q.discharge <= 1'b1;
      q.vout_mv <= 12'(`BC_VOUT_BASE_MV);
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign wb_dat_o = q.rdata;
  assign wb_ack_o = q.ack;
  assign irq_o = q.irq;
  assign mode_o = q.mode;
  assign discharge_o = q.discharge;
  assign ccm_o = q.ccm;
  assign hs_off_o = q.hs_off;
  assign ls_off_o = q.ls_off;
  assign vcode_o = q.vcode;
  assign vout_mv_o = q.vout_mv;

  // ==========================================================================
  // checks
  property p_off;
    @(posedge clk_i) disable iff (rst_i)
    !en && !wr |=> mode_o == BC_MODE_OFF && discharge_o;
  endproperty
  a_off: assert property (p_off) else $error("enabled while enable low");

  property p_fpwm;
    @(posedge clk_i) disable iff (rst_i)
    en && fpwm && pstate_i == BC_PS_RUN |=> mode_o == BC_MODE_FPWM && ccm_o;
  endproperty
  a_fpwm: assert property (p_fpwm) else $error("forced pwm not applied");

  property p_run_adapt;
    @(posedge clk_i) disable iff (rst_i)
    en && !fpwm && pstate_i == BC_PS_RUN |=> mode_o == BC_MODE_ADAPT;
  endproperty
  a_run_adapt: assert property (p_run_adapt) else $error("run not adaptive");

  property p_stby_off;
    @(posedge clk_i) disable iff (rst_i)
    pstate_i == BC_PS_STBY && !q.ctrl[`BC_CTRL_STBY_EN] |=> mode_o == BC_MODE_OFF;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("standby not off");

  property p_sleep_lowb;
    @(posedge clk_i) disable iff (rst_i)
    pstate_i == BC_PS_SLEEP && en && q.ctrl[`BC_CTRL_SLEEP_EN] && lowb && !fpwm
      |=> mode_o == BC_MODE_LOWB && !ccm_o;
  endproperty
  a_sleep_lowb: assert property (p_sleep_lowb) else $error("sleep low bias missed");

  property p_adapt_load;
    @(posedge clk_i) disable iff (rst_i)
    d.mode == BC_MODE_ADAPT |=> ccm_o == !$past(light_s);
  endproperty
  a_adapt_load: assert property (p_adapt_load) else $error("adaptive ccm wrong");

  property p_load;
    @(posedge clk_i) disable iff (rst_i)
    startup |=> q.vrun == $past(fused_code_i) && q.vslp == $past(fused_code_i);
  endproperty
  a_load: assert property (p_load) else $error("fused code not loaded");

  property p_ro;
    @(posedge clk_i) disable iff (rst_i)
    wr && !startup |=> $stable(q.vrun) && $stable(q.vstby) && $stable(q.vslp);
  endproperty
  a_ro: assert property (p_ro) else $error("voltage code written");

  property p_blank;
    @(posedge clk_i) disable iff (rst_i)
    lim_s[0] |=> hs_off_o;
  endproperty
  a_blank: assert property (p_blank) else $error("high-side blank missed");

  property p_hs_release;
    @(posedge clk_i) disable iff (rst_i)
    cycle_start_i && !lim_s[0] |=> !hs_off_o;
  endproperty
  a_hs_release: assert property (p_hs_release) else $error("high-side blank stuck");

  property p_ls_blank;
    @(posedge clk_i) disable iff (rst_i)
    lim_s[1] |=> ls_off_o;
  endproperty
  a_ls_blank: assert property (p_ls_blank) else $error("low-side blank missed");

  property p_ls_blank_hold;
    @(posedge clk_i) disable iff (rst_i)
    ls_off_o && !cycle_start_i |=> ls_off_o;
  endproperty
  a_ls_blank_hold: assert property (p_ls_blank_hold) else $error("low-side blank dropped");

  property p_blank_hold;
    @(posedge clk_i) disable iff (rst_i)
    hs_off_o && !cycle_start_i |=> hs_off_o;
  endproperty
  a_blank_hold: assert property (p_blank_hold) else $error("blank released early");

  property p_decode;
    @(posedge clk_i) disable iff (rst_i)
    vout_mv_o == 12'(`BC_VOUT_BASE_MV + `BC_VOUT_STEP_MV * int'(vcode_o));
  endproperty
  a_decode: assert property (p_decode) else $error("voltage decode wrong");

  property p_state_code;
    @(posedge clk_i) disable iff (rst_i)
    pstate_i == BC_PS_STBY |=> vcode_o == $past(q.vstby[3:0]);
  endproperty
  a_state_code: assert property (p_state_code) else $error("standby code not used");

  property p_status_set;
    @(posedge clk_i) disable iff (rst_i)
    |held |=> (q.status & $past(held)) == $past(held);
  endproperty
  a_status_set: assert property (p_status_set) else $error("persisted limit not flagged");

  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
    irq_o == |(q.status & q.mask);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held over two cycles");

  property p_sense;
    @(posedge clk_i) disable iff (rst_i)
    req && !wb_ack_o && {wb_adr_i[7:2], 2'b00} == `BC_ADR_SENSE
      |=> wb_dat_o == {30'h0, $past(lim_s)};
  endproperty
  a_sense: assert property (p_sense) else $error("sense read wrong");

  property p_stby_lowb;
    @(posedge clk_i) disable iff (rst_i)
    pstate_i == BC_PS_STBY && en && q.ctrl[`BC_CTRL_STBY_EN] && lowb && !fpwm
      |=> mode_o == BC_MODE_LOWB && !ccm_o;
  endproperty
  a_stby_lowb: assert property (p_stby_lowb) else $error("standby low bias missed");

  property p_discharge;
    @(posedge clk_i) disable iff (rst_i)
    discharge_o == (mode_o == BC_MODE_OFF);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge not tied to off");
endmodule // bc_top
